//--- scr_regs.vh
`ifndef SCR_REGS_VH
`define SCR_REGS_VH

// register addresses
`define SCR_ADDR_MOTION 6'h05
`define SCR_ADDR_FAULT_LOCK 6'h06
`define SCR_ADDR_STALL_CFG 6'h07
`define SCR_ADDR_STALL_LIMIT 6'h08

// motion_control fields
`define SCR_MC_DIR 7
`define SCR_MC_STEP 6
`define SCR_MC_DIR_SRC 5
`define SCR_MC_STEP_SRC 4
`define SCR_MC_USTEP_HI 3
`define SCR_MC_USTEP_LO 0
`define SCR_MC_USTEP_MAX 4'h a

// fault_lock_control fields
`define SCR_FL_CLR 7
`define SCR_FL_LOCK_HI 6
`define SCR_FL_LOCK_LO 4
`define SCR_FL_OL_EN 3
`define SCR_FL_OC_RESP 2
`define SCR_FL_OT_RESP 1
`define SCR_FL_WARN_REP 0
`define SCR_LOCK_CODE 3'h6
`define SCR_UNLOCK_CODE 3'h3

// stall_config fields
`define SCR_SC_LEARN 5
`define SCR_SC_EN 4
`define SCR_SC_REP 3
`define SCR_SC_OLW_HI 2
`define SCR_SC_OLW_LO 1
`define SCR_SC_BLANK 0

// reset values
`define SCR_RST_MOTION 8'h00
`define SCR_RST_FAULT_LOCK 8'h30
`define SCR_RST_STALL_CFG 8'h08
`define SCR_RST_STALL_LIMIT 8'h0f

`endif

//--- scr_sync2.v
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// two-stage pin synchroniser
// ----------------------------------------
module scr_sync2 (
   // clock and reset
   input wire sys_clk_i,
   input wire sys_rst_i,
   // pin in, synchronised out
   input wire pin_i,
   output wire sync_o
);

reg meta_ff;
reg sync_ff;

// first stage read only by second
always @(posedge sys_clk_i) begin
   if (sys_rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
   end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
   end
end

assign sync_o = sync_ff;

endmodule // scr_sync2
`default_nettype wire

//--- scr_stall_learn.v
`timescale 1ns/10ps
`default_nettype none
`include "scr_regs.vh"

// ----------------------------------------
// stall learning sequencer handshake
// ----------------------------------------
module scr_stall_learn (
   // clock and reset
   input wire sys_clk_i,
   input wire sys_rst_i,
   // start request and core completion
   input wire start_i,
   input wire learn_done_i,
   // status
   output wire busy_o,
   output wire start_pulse_o
);

localparam ST_IDLE = 1'b0;
localparam ST_BUSY = 1'b1;

reg state_ff;
reg nxt_state;
reg pulse_ff;

// idle until start, busy until core reports done
always @* begin
   nxt_state = state_ff;
   case (state_ff)
      ST_IDLE: begin
         if (start_i) begin
            nxt_state = ST_BUSY;
         end
      end
      ST_BUSY: begin
         if (learn_done_i) begin
            nxt_state = ST_IDLE;
         end
      end
      default: begin
         nxt_state = ST_IDLE;
      end
   endcase
end

// state and start pulse
always @(posedge sys_clk_i) begin
   if (sys_rst_i) begin
      state_ff <= ST_IDLE;
      pulse_ff <= 1'b0;
   end else begin
      state_ff <= nxt_state;
      pulse_ff <= start_i & (state_ff == ST_IDLE);
   end
end

assign busy_o = (state_ff == ST_BUSY);
assign start_pulse_o = pulse_ff;

endmodule // scr_stall_learn
`default_nettype wire

//--- scr_stepper_control_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "scr_regs.vh"

// Operation
// - direction from pin when source bit 0, from register bit when 1
// - step events from pin when source bit 0, from register when 1
// - register step write of 1 advances indexer one step when step source bit is 1
// - register step bit clears itself after a 1 is written
// - register direction bit sets rotation sense when selected
// - 4-bit microstep field selects full, half through 1/256 modes
// - clear-fault write of 1 clears latched faults, self-clears
// - lock code 110b blocks writes except lock field and clear-fault
// - 011b unlocks; other values ignored while locked; resets unlocked
// - open-load enable bit turns detection on, resets off
// - overcurrent response: latched when 0, auto retry when 1
// - overtemp response: latched when 0, auto recovery when 1
// - warning report forwards temperature warnings to fault pin
// - stall-learn write starts learning, bit clears when done
// - stall enable turns stall detection on, resets off
// - stall report signals stall on fault pin when stall enable is set, resets to 1
// - 2-bit open-load window field sets detection time
// - blanking select: fixed 500ns when 0, slew-dependent when 1
// - 8-bit stall threshold holds 0..255, resets to 0x0f

module scr_stepper_control_regs (
   // clock and reset
   input wire sys_clk_i,
   input wire sys_rst_i,
   // register access from serial interface
   input wire wr_en_i,
   input wire [5:0] addr_i,
   input wire [7:0] wdata_i,
   output reg [7:0] rdata_o,
   // external motion pins
   input wire dir_pin_i,
   input wire step_pin_i,
   // fault sources from core
   input wire fault_any_i,
   input wire temp_warn_i,
   input wire stall_det_i,
   input wire learn_done_i,
   // indexer controls
   output reg step_o,
   output reg dir_o,
   output reg [3:0] microstep_mode_o,
   // protection controls
   output reg clear_fault_o,
   output reg open_load_enable_o,
   output reg overcurrent_response_o,
   output reg overtemp_response_o,
   output reg stall_enable_o,
   output reg [1:0] open_load_window_o,
   output reg blanking_select_o,
   output reg [7:0] stall_limit_count_o,
   output reg stall_learn_start_o,
   output reg locked_o,
   // fault pin
   output reg fault_out_n_o
);

// ----------------------------------------
// storage
// ----------------------------------------
reg dir_bit_ff;
reg dir_src_ff;
reg step_src_ff;
reg [3:0] ustep_ff;
reg [2:0] lock_ff;
reg ol_en_ff;
reg oc_resp_ff;
reg ot_resp_ff;
reg warn_rep_ff;
reg stall_en_ff;
reg stall_rep_ff;
reg [1:0] olw_ff;
reg blank_ff;
reg [7:0] stall_lim_ff;
reg reg_step_ff;
reg clr_ff;
reg step_pin_d_ff;

wire dir_pin_s;
wire step_pin_s;
wire learn_busy;
wire learn_pulse;
wire is_locked;
wire wr_motion;
wire wr_fl;
wire wr_sc;
wire wr_sl;

// reset images of the three mixed registers
localparam [7:0] RST_MC = `SCR_RST_MOTION;
localparam [7:0] RST_FL = `SCR_RST_FAULT_LOCK;
localparam [7:0] RST_SC = `SCR_RST_STALL_CFG;

// decode one address against a write strobe
function wr_hit;
   input en;
   input [5:0] a;
   input [5:0] target;
   begin
      wr_hit = en & (a == target);
   end
endfunction

// lock field of a fault_lock_control write equals a code
function lock_is;
   input [7:0] d;
   input [2:0] code;
   begin
      lock_is = (d[`SCR_FL_LOCK_HI:`SCR_FL_LOCK_LO] == code);
   end
endfunction

// ----------------------------------------
// pin synchronisers and learn sequencer
// ----------------------------------------
scr_sync2 u_sync_dir (
   .sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i),
   .pin_i(dir_pin_i),
   .sync_o(dir_pin_s)
);

scr_sync2 u_sync_step (
   .sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i),
   .pin_i(step_pin_i),
   .sync_o(step_pin_s)
);

scr_stall_learn u_learn (
   .sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i),
   .start_i(wr_sc & wdata_i[`SCR_SC_LEARN]),
   .learn_done_i(learn_done_i),
   .busy_o(learn_busy),
   .start_pulse_o(learn_pulse)
);

// ----------------------------------------
// write decode with lock gating
// ----------------------------------------
// locked blocks writes except to fault_lock_control
assign is_locked = (lock_ff == `SCR_LOCK_CODE);
assign wr_motion = wr_hit(wr_en_i, addr_i, `SCR_ADDR_MOTION) & ~is_locked;
assign wr_fl = wr_hit(wr_en_i, addr_i, `SCR_ADDR_FAULT_LOCK);
assign wr_sc = wr_hit(wr_en_i, addr_i, `SCR_ADDR_STALL_CFG) & ~is_locked;
assign wr_sl = wr_hit(wr_en_i, addr_i, `SCR_ADDR_STALL_LIMIT) & ~is_locked;

// ----------------------------------------
// register writes
// ----------------------------------------
always @(posedge sys_clk_i) begin
   if (sys_rst_i) begin
      dir_bit_ff <= RST_MC[`SCR_MC_DIR];
      dir_src_ff <= RST_MC[`SCR_MC_DIR_SRC];
      step_src_ff <= RST_MC[`SCR_MC_STEP_SRC];
      ustep_ff <= RST_MC[`SCR_MC_USTEP_HI:`SCR_MC_USTEP_LO];
      lock_ff <= RST_FL[`SCR_FL_LOCK_HI:`SCR_FL_LOCK_LO];
      ol_en_ff <= RST_FL[`SCR_FL_OL_EN];
      oc_resp_ff <= RST_FL[`SCR_FL_OC_RESP];
      ot_resp_ff <= RST_FL[`SCR_FL_OT_RESP];
      warn_rep_ff <= RST_FL[`SCR_FL_WARN_REP];
      stall_en_ff <= RST_SC[`SCR_SC_EN];
      stall_rep_ff <= RST_SC[`SCR_SC_REP];
      olw_ff <= RST_SC[`SCR_SC_OLW_HI:`SCR_SC_OLW_LO];
      blank_ff <= RST_SC[`SCR_SC_BLANK];
      stall_lim_ff <= `SCR_RST_STALL_LIMIT;
      reg_step_ff <= RST_MC[`SCR_MC_STEP];
      clr_ff <= RST_FL[`SCR_FL_CLR];
   end else begin
      reg_step_ff <= 1'b0;
      clr_ff <= 1'b0;
      if (wr_motion) begin
         dir_bit_ff <= wdata_i[`SCR_MC_DIR];
         dir_src_ff <= wdata_i[`SCR_MC_DIR_SRC];
         step_src_ff <= wdata_i[`SCR_MC_STEP_SRC];
         ustep_ff <= wdata_i[`SCR_MC_USTEP_HI:`SCR_MC_USTEP_LO];
         // one step per write of 1
         reg_step_ff <= wdata_i[`SCR_MC_STEP];
      end
      if (wr_fl) begin
         clr_ff <= wdata_i[`SCR_FL_CLR];
         if (!is_locked) begin
            if (lock_is(wdata_i, `SCR_LOCK_CODE)) begin
               lock_ff <= `SCR_LOCK_CODE;
            end
            ol_en_ff <= wdata_i[`SCR_FL_OL_EN];
            oc_resp_ff <= wdata_i[`SCR_FL_OC_RESP];
            ot_resp_ff <= wdata_i[`SCR_FL_OT_RESP];
            warn_rep_ff <= wdata_i[`SCR_FL_WARN_REP];
         end else if (lock_is(wdata_i, `SCR_UNLOCK_CODE)) begin
            lock_ff <= `SCR_UNLOCK_CODE;
         end
      end
      if (wr_sc) begin
         stall_en_ff <= wdata_i[`SCR_SC_EN];
         stall_rep_ff <= wdata_i[`SCR_SC_REP];
         olw_ff <= wdata_i[`SCR_SC_OLW_HI:`SCR_SC_OLW_LO];
         blank_ff <= wdata_i[`SCR_SC_BLANK];
      end
      if (wr_sl) begin
         stall_lim_ff <= wdata_i;
      end
   end
end

// ----------------------------------------
// outputs to the indexer and core
// ----------------------------------------
always @(posedge sys_clk_i) begin
   if (sys_rst_i) begin
      step_pin_d_ff <= 1'b0;
      step_o <= 1'b0;
      dir_o <= RST_MC[`SCR_MC_DIR];
      microstep_mode_o <= RST_MC[`SCR_MC_USTEP_HI:`SCR_MC_USTEP_LO];
      clear_fault_o <= RST_FL[`SCR_FL_CLR];
      open_load_enable_o <= RST_FL[`SCR_FL_OL_EN];
      overcurrent_response_o <= RST_FL[`SCR_FL_OC_RESP];
      overtemp_response_o <= RST_FL[`SCR_FL_OT_RESP];
      stall_enable_o <= RST_SC[`SCR_SC_EN];
      open_load_window_o <= RST_SC[`SCR_SC_OLW_HI:`SCR_SC_OLW_LO];
      blanking_select_o <= RST_SC[`SCR_SC_BLANK];
      stall_limit_count_o <= `SCR_RST_STALL_LIMIT;
      stall_learn_start_o <= 1'b0;
      locked_o <= 1'b0;
      fault_out_n_o <= 1'b1;
   end else begin
      step_pin_d_ff <= step_pin_s;
      // step source select, pin rising edge or register pulse
      step_o <= step_src_ff ? reg_step_ff : (step_pin_s & ~step_pin_d_ff);
      dir_o <= dir_src_ff ? dir_bit_ff : dir_pin_s;
      microstep_mode_o <= ustep_ff;
      clear_fault_o <= clr_ff;
      open_load_enable_o <= ol_en_ff;
      overcurrent_response_o <= oc_resp_ff;
      overtemp_response_o <= ot_resp_ff;
      stall_enable_o <= stall_en_ff;
      open_load_window_o <= olw_ff;
      blanking_select_o <= blank_ff;
      stall_limit_count_o <= stall_lim_ff;
      stall_learn_start_o <= learn_pulse;
      locked_o <= is_locked;
      fault_out_n_o <= ~(fault_any_i | (warn_rep_ff & temp_warn_i) |
                         (stall_rep_ff & stall_en_ff & stall_det_i));
   end
end

// ----------------------------------------
// read mux
// ----------------------------------------
// self-clearing bits read as pending state
always @(posedge sys_clk_i) begin
   if (sys_rst_i) begin
      rdata_o <= 8'h00;
   end else begin
      case (addr_i)
         `SCR_ADDR_MOTION: begin
            rdata_o <= {dir_bit_ff, reg_step_ff, dir_src_ff, step_src_ff,
                        ustep_ff};
         end
         `SCR_ADDR_FAULT_LOCK: begin
            rdata_o <= {clr_ff, lock_ff, ol_en_ff, oc_resp_ff, ot_resp_ff,
                        warn_rep_ff};
         end
         `SCR_ADDR_STALL_CFG: begin
            rdata_o <= {2'b00, learn_busy, stall_en_ff, stall_rep_ff, olw_ff,
                        blank_ff};
         end
         `SCR_ADDR_STALL_LIMIT: begin
            rdata_o <= stall_lim_ff;
         end
         default: begin
            rdata_o <= 8'h00;
         end
      endcase
   end
end

endmodule // scr_stepper_control_regs
`default_nettype wire

//--- scr_regs_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ----------
// bank checker
// ----------
module scr_regs_checker (
   // clock and reset
   input wire sys_clk_i,
   input wire sys_rst_i,
   // register writes
   input wire wr_en_i,
   input wire [5:0] addr_i,
   input wire [7:0] wdata_i,
   // watched outputs
   input wire step_o,
   input wire clear_fault_o,
   input wire stall_learn_start_o,
   input wire locked_o,
   input wire [7:0] stall_limit_count_o,
   input wire fault_out_n_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // write decode for lock and limit registers
   wire wr6 = wr_en_i && addr_i == 6'h06;
   wire wr8 = wr_en_i && addr_i == 6'h08;
   property p_step;
      step_o |=> !step_o;
   endproperty
   a_step: assert property (p_step) else $error("step long");
   property p_clr;
      clear_fault_o |=> !clear_fault_o;
   endproperty
   a_clr: assert property (p_clr) else $error("clear long");
   property p_lrn;
      stall_learn_start_o |=> !stall_learn_start_o;
   endproperty
   a_lrn: assert property (p_lrn) else $error("learn long");
   property p_rst;
      $fell(sys_rst_i) |-> !locked_o && fault_out_n_o &&
         stall_limit_count_o == 8'h0f;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset");
   property p_lock;
      wr6 && wdata_i[6:4] == 3'h6 |-> ##[1:3] locked_o;
   endproperty
   a_lock: assert property (p_lock) else $error("no lock");
   property p_unlk;
      wr6 && wdata_i[6:4] == 3'h3 |-> ##[1:3] !locked_o;
   endproperty
   a_unlk: assert property (p_unlk) else $error("no unlock");
   property p_nolk;
      !locked_o && wr6 && wdata_i[6:4] != 3'h6 && !$past(wr_en_i)
         |=> !locked_o [*3];
   endproperty
   a_nolk: assert property (p_nolk) else $error("false lock");
   property p_hold;
      locked_o && wr8 && !$past(wr_en_i)
         |=> $stable(stall_limit_count_o) [*3];
   endproperty
   a_hold: assert property (p_hold) else $error("write leak");
   property p_lim;
      !locked_o && wr8 && !$past(wr_en_i)
         |-> ##2 stall_limit_count_o == $past(wdata_i, 2);
   endproperty
   a_lim: assert property (p_lim) else $error("limit lost");
endmodule // scr_regs_checker

bind scr_stepper_control_regs scr_regs_checker u_chk (
   .sys_clk_i, .sys_rst_i, .wr_en_i, .addr_i, .wdata_i, .step_o,
   .clear_fault_o, .stall_learn_start_o, .locked_o,
   .stall_limit_count_o, .fault_out_n_o
);
`default_nettype wire

//--- scr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------
// host model
// ----------
module scr_host_model (
   // clock
   input wire sys_clk_i,
   // register access
   output logic wr_en_o,
   output logic [5:0] addr_o,
   output logic [7:0] wdata_o,
   input wire [7:0] rdata_i
);
   // idle bus at start
   initial begin
      wr_en_o = 1'b0;
      addr_o = 6'h00;
      wdata_o = 8'h00;
   end
   // one write, strobe seen at one edge
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      if (a == 6'h05 && d[3:0] > 4'ha) d[3:0] = 4'ha;
      if (a == 6'h07) d[7:6] = 2'h0;
      @(posedge sys_clk_i);
      wr_en_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge sys_clk_i);
      wr_en_o <= 1'b0;
   endtask
   // one read, data one edge after address
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      addr_o <= a;
      @(posedge sys_clk_i);
      #1 d = rdata_i;
   endtask
endmodule // scr_host_model
`default_nettype wire

//--- test_stepper_control_regs.sv
`timescale 1ns/10ps
`default_nettype none
// ----------
// bench top
// ----------
module test_stepper_control_regs;
   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, dir_pin_i = 1'b0;
   logic step_pin_i = 1'b0, fault_any_i = 1'b0, temp_warn_i = 1'b0;
   logic stall_det_i = 1'b0, learn_done_i = 1'b0;
   wire wr_en_i, step_o, dir_o, clear_fault_o, open_load_enable_o;
   wire overcurrent_response_o, overtemp_response_o, stall_enable_o;
   wire blanking_select_o, stall_learn_start_o, locked_o, fault_out_n_o;
   wire [5:0] addr_i;
   wire [7:0] wdata_i, rdata_o, stall_limit_count_o;
   wire [3:0] microstep_mode_o;
   wire [1:0] open_load_window_o;
   int errors = 0, cmp_count = 0, cyc = 0, ns = 0, nc = 0, nl = 0, b;
   logic [7:0] mc = 8'h00, fl = 8'h30, sc = 8'h08, sl = 8'h0f, r;
   // indexer and protection levels as one vector
   wire [19:0] outs = {microstep_mode_o, open_load_enable_o,
      overcurrent_response_o, overtemp_response_o, stall_enable_o,
      open_load_window_o, blanking_select_o, stall_limit_count_o, dir_o};
   // device under test
   scr_stepper_control_regs uut (
      .sys_clk_i, .sys_rst_i, .wr_en_i, .addr_i, .wdata_i, .rdata_o,
      .dir_pin_i, .step_pin_i, .fault_any_i, .temp_warn_i, .stall_det_i,
      .learn_done_i, .step_o, .dir_o, .microstep_mode_o, .clear_fault_o,
      .open_load_enable_o, .overcurrent_response_o, .overtemp_response_o,
      .stall_enable_o, .open_load_window_o, .blanking_select_o,
      .stall_limit_count_o, .stall_learn_start_o, .locked_o, .fault_out_n_o
   );
   // host on the register side
   scr_host_model host (
      .sys_clk_i, .wr_en_o(wr_en_i), .addr_o(addr_i), .wdata_o(wdata_i),
      .rdata_i(rdata_o)
   );
   // 200 MHz clock
   always #2.5 sys_clk_i = ~sys_clk_i;
   // pulse counters and hang guard
   always @(posedge sys_clk_i) begin
      ns <= ns + int'(step_o === 1'b1);
      nc <= nc + int'(clear_fault_o === 1'b1);
      nl <= nl + int'(stall_learn_start_o === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors = errors + 1;
         conclude();
      end
   end
   task automatic conclude();
      if (errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [19:0] g, input logic [19:0] e);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic rchk(input logic [5:0] a, input logic [7:0] e);
      host.rd(a, r);
      chk(20'(r), 20'(e));
   endtask
   // write and track the stored value
   task automatic put(input logic [5:0] a, input logic [7:0] d);
      host.wr(a, d);
      if (a == 6'h05) mc = d & 8'hbf;
      if (a == 6'h06) fl = d & 8'h7f;
      if (a == 6'h07) sc = d & 8'hdf;
      if (a == 6'h08) sl = d;
   endtask
   task automatic pin();
      @(posedge sys_clk_i) step_pin_i <= 1'b1;
      w(4);
      step_pin_i <= 1'b0;
      w(4);
   endtask
   function automatic logic [7:0] exp_rd(input logic [5:0] a);
      exp_rd = a == 6'h05 ? mc : a == 6'h06 ? fl : a == 6'h07 ? sc : sl;
   endfunction
   function automatic logic [19:0] exp_out();
      exp_out = {mc[3:0], fl[3:1], sc[4], sc[2:0], sl,
         mc[5] ? mc[7] : dir_pin_i};
   endfunction
   // main sequence
   initial begin
      int i;
      logic [5:0] a;
      logic [7:0] d;
      void'($urandom(76));
      w(4);
      sys_rst_i <= 1'b0;
      rchk(6'h05, 8'h00);
      rchk(6'h06, 8'h30);
      rchk(6'h07, 8'h08);
      rchk(6'h08, 8'h0f);
      rchk(6'h3f, 8'h00);
      for (i = 0; i < 11; i++) begin
         put(6'h05, 8'(i));
         w(4);
         chk(20'(microstep_mode_o), 20'(i));
      end
      for (i = 0; i < 24; i++) begin
         a = 6'h05 + 6'($urandom % 4);
         d = 8'($urandom);
         if (a == 6'h05) d = {d[7], 1'b0, d[5:4], 4'($urandom % 11)};
         if (a == 6'h06) d = {4'h3, d[3:0]};
         if (a == 6'h07) d = d & 8'h1f;
         @(posedge sys_clk_i) dir_pin_i <= 1'($urandom);
         put(a, d);
         w(6);
         chk(outs, exp_out());
         rchk(a, exp_rd(a));
      end
      // register step, three writes in a row
      put(6'h05, 8'hb0);
      b = ns;
      repeat (3) host.wr(6'h05, 8'hf0);
      w(6);
      chk(20'(ns - b), 20'd3);
      rchk(6'h05, mc);
      chk(outs, exp_out());
      // pin steps count only with pin source
      put(6'h05, 8'h00);
      b = ns;
      pin();
      pin();
      put(6'h05, 8'h10);
      pin();
      chk(20'(ns - b), 20'd2);
      // lock, blocked writes, clear while locked
      b = nc;
      put(6'h08, 8'h5a);
      put(6'h06, 8'h60);
      host.wr(6'h08, 8'ha5);
      host.wr(6'h06, 8'h5f);
      host.wr(6'h06, 8'he0);
      w(6);
      chk(20'(locked_o), 20'd1);
      rchk(6'h08, sl);
      rchk(6'h06, fl);
      chk(20'(nc - b), 20'd1);
      host.wr(6'h06, 8'h30);
      host.wr(6'h06, 8'h40);
      fl = 8'h30;
      w(6);
      chk(20'(locked_o), 20'd0);
      put(6'h08, 8'ha5);
      rchk(6'h08, sl);
      // stall learning handshake
      b = nl;
      put(6'h07, 8'h28);
      rchk(6'h07, 8'h28);
      @(posedge sys_clk_i) learn_done_i <= 1'b1;
      @(posedge sys_clk_i) learn_done_i <= 1'b0;
      w(4);
      rchk(6'h07, sc);
      chk(20'(nl - b), 20'd1);
      // fault pin reporting
      @(posedge sys_clk_i) temp_warn_i <= 1'b1;
      w(6);
      chk(20'(fault_out_n_o), 20'd1);
      put(6'h06, 8'h31);
      w(6);
      chk(20'(fault_out_n_o), 20'd0);
      put(6'h06, 8'h30);
      temp_warn_i <= 1'b0;
      stall_det_i <= 1'b1;
      w(6);
      chk(20'(fault_out_n_o), 20'd1);
      put(6'h07, 8'h10);
      w(6);
      chk(20'(fault_out_n_o), 20'd1);
      put(6'h07, 8'h18);
      w(6);
      chk(20'(fault_out_n_o), 20'd0);
      // core fault always reaches the pin, warnings aside
      stall_det_i <= 1'b0;
      fault_any_i <= 1'b1;
      w(6);
      chk(20'(fault_out_n_o), 20'd0);
      fault_any_i <= 1'b0;
      w(6);
      chk(20'(fault_out_n_o), 20'd1);
      conclude();
   end
endmodule // test_stepper_control_regs
`default_nettype wire
